// >>> hdl/tsf_event_detect.sv
`timescale 1ns/1ns
module tsf_event_detect #(
  parameter int unsigned CNT_W = 16,
  parameter int unsigned N     = 4
) (
  input  wire logic                      clk_i,   // Clock
  input  wire logic                      rst_i,   // Sync reset, active high
  input  wire logic                      ce_i,    // Clock enable
  input  wire logic [CNT_W-1:0]          cnt_i,   // Counter value
  input  wire logic [N-1:0][CNT_W-1:0]   cmp_i,   // Compare values
  output logic                           ovf_o,   // Wrap from max to zero
  output logic [N-1:0]                   match_o  // Counter moved onto a compare value
);

  if (CNT_W < 2 || N < 1) begin : g_chk
    $error("tsf_event_detect: unsupported CNT_W or N");
  end

  logic [CNT_W-1:0] prev_q;
  logic             moved;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev_q <= '0;
    end else if (ce_i) begin
      prev_q <= cnt_i;
    end
  end

  // A stopped counter sitting on a compare value does not re-fire after a clear
  assign moved = (cnt_i != prev_q);
  assign ovf_o = ce_i && (prev_q == {CNT_W{1'b1}}) && (cnt_i == '0);

  for (genvar i = 0; i < N; i++) begin : g_cmp
    assign match_o[i] = ce_i && moved && (cnt_i == cmp_i[i]);
  end

endmodule

// >>> hdl/tsf_flag_bank.sv
`timescale 1ns/1ns
module tsf_flag_bank #(
  parameter int unsigned  W    = 16,
  parameter logic [W-1:0] IMPL = '1
) (
  input  wire logic          clk_i,    // Clock
  input  wire logic          rst_i,    // Sync reset, active high
  input  wire logic          ce_i,     // Clock enable
  input  wire logic [W-1:0]  set_i,    // Hardware set events
  input  wire logic          arm_i,    // Read of this register completes
  input  wire logic [W-1:0]  rd_val_i, // Value that the read returned
  input  wire logic          wr_i,     // Write of this register completes
  input  wire logic [W-1:0]  wdata_i,  // Write data
  input  wire logic [W-1:0]  wlane_i,  // Per-bit byte-lane enable
  output logic [W-1:0]       flags_o   // Sticky flags
);

  if (W < 1) begin : g_chk
    $error("tsf_flag_bank: W must be at least 1");
  end

  for (genvar k = 0; k < W; k++) begin : g_bit
    if (IMPL[k]) begin : g_flag
      logic flag_q;
      logic armed_q;
      logic clr;

      // Clear only on a zero write after this bit was read as one
      assign clr = wr_i && wlane_i[k] && !wdata_i[k] && armed_q; // R02 R04 R05 R09 R13

      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          flag_q <= 1'b0; // R19
        end else if (ce_i) begin
          flag_q <= set_i[k] || (flag_q && !clr); // R18 R19
        end
      end

      // Any write through the lane uses up the arming, so a later stray zero cannot clear
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          armed_q <= 1'b0;
        end else if (ce_i) begin
          if (arm_i && rd_val_i[k] && flag_q) begin
            armed_q <= 1'b1;
          end else if (!flag_q || (wr_i && wlane_i[k])) begin
            armed_q <= 1'b0;
          end
        end
      end

      assign flags_o[k] = flag_q;
    end else begin : g_rsv
      assign flags_o[k] = 1'b0;
    end
  end

endmodule

// >>> hdl/tsf_pkg.sv
package tsf_pkg;

  // Widths of the counters and of the compare sets
  localparam int unsigned TSF_CNT_W     = 16;
  localparam int unsigned TSF_N_CMP2B   = 8;
  localparam int unsigned TSF_N_GR      = 4;
  localparam int unsigned TSF_N_CH      = 3;
  localparam int unsigned TSF_REG_W     = 16;
  localparam int unsigned TSF_ADR_W     = 8;

  // Register byte offsets on the bus
  localparam logic [7:0] TSF_OFS_ST2B   = 8'h00;
  localparam logic [7:0] TSF_OFS_ST3    = 8'h04;
  localparam logic [7:0] TSF_OFS_MASK2B = 8'h08;
  localparam logic [7:0] TSF_OFS_MASK3  = 8'h0c;
  localparam logic [7:0] TSF_OFS_MODE   = 8'h10;

  // Field positions
  localparam int unsigned TSF_CH2_SECOND_COUNTER_OVERFLOW_FLAG_BIT   = 8;
  localparam int unsigned TSF_CH3_OVF_BIT = 4;
  localparam int unsigned TSF_CH_STRIDE   = 5;
  localparam int unsigned TSF_RSV3_BIT    = 15;
  localparam int unsigned TSF_MODE_CAP_LSB = 0;
  localparam int unsigned TSF_MODE_PWM_LSB = 12;
  localparam int unsigned TSF_MODE_W       = 15;

  // Bits that hold a flag; all others read as zero
  localparam logic [15:0] TSF_ST2B_IMPL = 16'h01ff;
  localparam logic [15:0] TSF_ST3_IMPL  = 16'h7fff;
  localparam logic [14:0] TSF_MODE_IMPL = 15'h7fff;

  // Reset values
  localparam logic [15:0] TSF_ST_RST   = 16'h0000;
  localparam logic [15:0] TSF_MASK_RST = 16'h0000;
  localparam logic [14:0] TSF_MODE_RST = 15'h0000;

  // One channel of the 3 to 5 group, as seen from the counter logic
  typedef struct packed {
    logic [3:0]        capture;
    logic [3:0][15:0]  gr;
    logic [15:0]       cnt;
  } tsf_chan_t;

  // Channel 2 second counter and its eight output compare values
  typedef struct packed {
    logic [7:0][15:0]  ocr;
    logic [15:0]       cnt;
  } tsf_ch2b_t;

  // Software mode settings: capture/compare select per register, PWM per channel
  typedef struct packed {
    logic [2:0]        pwm;
    logic [2:0][3:0]   capture_mode;
  } tsf_mode_t;

endpackage

// >>> hdl/tsf_status_top.sv
// Function
// (R01) Set second-counter overflow flag on wrap
// (R02) Overflow flag clears by read one, write zero
// (R03) Set match flag when counter equals compare
// (R04) Match flags clear by read one, write zero
// (R05) Writing one to a flag does nothing
// (R06) Channel 5/4/3 overflow at bits 14/9/4
// (R07) Bit 15 of group register reads zero
// (R08) Set channel 5 overflow flag on wrap
// (R09) Channel 5 overflow clears by read-write sequence
// (R10) Capture into fourth channel 5 register sets flag
// (R11) Compare match on fourth register sets flag
// (R12) PWM cycle register match sets bit 13
// (R13) Bit 13 clears by read one, write zero
// (R14) Bit 12 never set in PWM mode
// (R15) Bit 12 set on capture or compare
// (R16) Set channel 4 overflow flag on wrap
// (R17) Channel 4 sync register match sets bit 8
// (R18) Set beats a clear in same cycle
// (R19) Flags reset to zero, stay until cleared
//
// Added by the designer: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ns
module tsf_status_top
  import tsf_pkg::*;
#(
  parameter int unsigned CNT_W = tsf_pkg::TSF_CNT_W
) (
  input  wire logic                         clk_i,       // Clock, 250 MHz
  input  wire logic                         rst_i,       // Sync reset, active high
  input  wire logic                         ce_i,        // Clock enable, freezes all state
  input  wire logic                         wb_cyc_i,    // Wishbone cycle
  input  wire logic                         wb_stb_i,    // Wishbone strobe
  input  wire logic                         wb_we_i,     // Wishbone write enable
  input  wire logic [7:0]                   wb_adr_i,    // Wishbone byte address
  input  wire logic [3:0]                   wb_sel_i,    // Wishbone byte selects
  input  wire logic [31:0]                  wb_dat_i,    // Wishbone write data
  output logic                              wb_ack_o,    // Wishbone acknowledge
  output logic [31:0]                       wb_dat_o,    // Wishbone read data
  input  wire tsf_pkg::tsf_ch2b_t           ch2b_i,      // Second counter and compares
  input  wire tsf_pkg::tsf_chan_t [2:0]     chan_i,      // Channels 3 to 5
  output logic [15:0]                       st2b_o,      // Second-counter status flags
  output logic [15:0]                       st3_o,       // Channels 3 to 5 status flags
  output tsf_pkg::tsf_mode_t                mode_o,      // Mode settings in force
  output logic                              irq_o        // Level interrupt
);

  import tsf_pkg::*;

  if (CNT_W != TSF_CNT_W) begin : g_chk
    $error("tsf_status_top: counters are 16 bits wide");
  end

  // Bus slave -------------------------------------------------------------

  logic        req;
  logic        ack_q;
  logic [31:0] dat_q;
  logic [7:0]  adr_word;
  logic        commit;
  logic        wr_commit;
  logic        rd_commit;
  logic [15:0] lane;
  logic [31:0] rd_mux;

  assign req      = wb_cyc_i && wb_stb_i;
  assign adr_word = {wb_adr_i[7:2], 2'b00};
  assign lane     = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  // Register effects land on the edge where the master sees ack
  assign commit    = req && ack_q;
  assign wr_commit = commit && wb_we_i;
  assign rd_commit = commit && !wb_we_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else if (ce_i) begin
      ack_q <= req && !ack_q;
    end
  end

  // Read value is sampled on the first edge of the request and held with ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_q <= '0;
    end else if (ce_i && req && !ack_q) begin
      dat_q <= wb_we_i ? 32'h0000_0000 : rd_mux;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  // Flag storage ----------------------------------------------------------

  logic [15:0] st2b;
  logic [15:0] st3;
  logic [15:0] set2b;
  logic [15:0] set3;
  logic        sel_st2b;
  logic        sel_st3;
  logic        sel_mask2b;
  logic        sel_mask3;
  logic        sel_mode;

  assign sel_st2b   = (adr_word == TSF_OFS_ST2B);
  assign sel_st3    = (adr_word == TSF_OFS_ST3);
  assign sel_mask2b = (adr_word == TSF_OFS_MASK2B);
  assign sel_mask3  = (adr_word == TSF_OFS_MASK3);
  assign sel_mode   = (adr_word == TSF_OFS_MODE);

  tsf_flag_bank #(
    .W    (TSF_REG_W),
    .IMPL (TSF_ST2B_IMPL)
  ) u_bank2b (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .ce_i     (ce_i),
    .set_i    (set2b),
    .arm_i    (rd_commit && sel_st2b),
    .rd_val_i (dat_q[15:0]),
    .wr_i     (wr_commit && sel_st2b),
    .wdata_i  (wb_dat_i[15:0]),
    .wlane_i  (lane),
    .flags_o  (st2b)
  );

  tsf_flag_bank #(
    .W    (TSF_REG_W),
    .IMPL (TSF_ST3_IMPL)
  ) u_bank3 (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .ce_i     (ce_i),
    .set_i    (set3),
    .arm_i    (rd_commit && sel_st3),
    .rd_val_i (dat_q[15:0]),
    .wr_i     (wr_commit && sel_st3),
    .wdata_i  (wb_dat_i[15:0]),
    .wlane_i  (lane),
    .flags_o  (st3)
  );

  assign st2b_o = st2b;
  assign st3_o  = st3;

  // Mask and mode registers -----------------------------------------------

  logic [15:0] mask2b_q;
  logic [15:0] mask3_q;
  logic [14:0] mode_q;
  tsf_mode_t   mode;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask2b_q <= TSF_MASK_RST;
    end else if (ce_i && wr_commit && sel_mask2b) begin
      mask2b_q <= ((wb_dat_i[15:0] & lane) | (mask2b_q & ~lane)) & TSF_ST2B_IMPL;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask3_q <= TSF_MASK_RST;
    end else if (ce_i && wr_commit && sel_mask3) begin
      mask3_q <= ((wb_dat_i[15:0] & lane) | (mask3_q & ~lane)) & TSF_ST3_IMPL;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_q <= TSF_MODE_RST;
    end else if (ce_i && wr_commit && sel_mode) begin
      mode_q <= ((wb_dat_i[14:0] & lane[14:0]) | (mode_q & ~lane[14:0])) & TSF_MODE_IMPL;
    end
  end

  assign mode   = tsf_mode_t'(mode_q);
  assign mode_o = mode;

  // Unmapped offsets answer with zero and ignore writes
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (1'b1)
      sel_st2b:   rd_mux[15:0] = st2b & TSF_ST2B_IMPL;
      sel_st3:    rd_mux[15:0] = st3 & TSF_ST3_IMPL; // R07
      sel_mask2b: rd_mux[15:0] = mask2b_q;
      sel_mask3:  rd_mux[15:0] = mask3_q;
      sel_mode:   rd_mux[14:0] = mode_q;
      default:    rd_mux = 32'h0000_0000;
    endcase
  end

  // Channel 2 second counter events ---------------------------------------

  logic       ch2_second_counter_overflow_flag;
  logic [7:0] match2b;

  tsf_event_detect #(
    .CNT_W (TSF_CNT_W),
    .N     (TSF_N_CMP2B)
  ) u_evt2b (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .ce_i    (ce_i),
    .cnt_i   (ch2b_i.cnt),
    .cmp_i   (ch2b_i.ocr),
    .ovf_o   (ch2_second_counter_overflow_flag),
    .match_o (match2b)
  );

  // Overflow at bit 8, match flags h..a at bits 7..0
  assign set2b = {7'h00, ch2_second_counter_overflow_flag, match2b}; // R01 R03

  // Channels 3 to 5 events --------------------------------------------------

  for (genvar c = 0; c < TSF_N_CH; c++) begin : g_ch
    logic       ovf;
    logic [3:0] match;
    logic [3:0] gr_set;
    logic [4:0] s;

    tsf_event_detect #(
      .CNT_W (TSF_CNT_W),
      .N     (TSF_N_GR)
    ) u_evt (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .ce_i    (ce_i),
      .cnt_i   (chan_i[c].cnt),
      .cmp_i   (chan_i[c].gr),
      .ovf_o   (ovf),
      .match_o (match)
    );

    for (genvar i = 0; i < TSF_N_GR; i++) begin : g_gr
      if (i == TSF_N_GR - 1) begin : g_d
        // Fourth register is cycle (ch5) or sync (ch4) register under PWM
        assign gr_set[i] = mode.pwm[c] ? match[i] // R12 R17
                         : mode.capture_mode[c][i] ? (ce_i && chan_i[c].capture[i]) // R10
                         : match[i]; // R11
      end else begin : g_abc
        // The other three stay silent under PWM
        assign gr_set[i] = !mode.pwm[c] && // R14
                           (mode.capture_mode[c][i] ? (ce_i && chan_i[c].capture[i])
                                                    : match[i]); // R15
      end
    end

    // Overflow on top, flags d..a below it
    assign s = {ovf, gr_set}; // R08 R16
  end

  // Channel 5, 4, 3 fields at bits 14:10, 9:5, 4:0; bit 15 reserved
  assign set3 = {1'b0, g_ch[2].s, g_ch[1].s, g_ch[0].s}; // R06 R07

  // Interrupt ---------------------------------------------------------------

  logic irq_q;

  // Registered, so the level trails the flag by one cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_q <= 1'b0;
    end else if (ce_i) begin
      irq_q <= |((st2b & mask2b_q) | (st3 & mask3_q));
    end
  end

  assign irq_o = irq_q;

endmodule

// >>> test/tb_tsf_status_top.sv
`timescale 1ns/1ns
module tb_tsf_status_top;
  import tsf_pkg::*;
  logic            clk_i = 1'b0;
  logic            rst_i = 1'b1;
  logic            ce_i = 1'b1;
  logic [3:0]      wb_sel_i = 4'h0;
  logic [3:0]      bsel = 4'h3;
  logic            wb_cyc_i = 1'b0;
  logic            wb_stb_i = 1'b0;
  logic            wb_we_i = 1'b0;
  logic [7:0]      wb_adr_i = 8'h00;
  logic [31:0]     wb_dat_i = 32'h0;
  logic            wb_ack_o;
  logic [31:0]     wb_dat_o;
  logic [15:0]     st2b_o;
  logic [15:0]     st3_o;
  logic            irq_o;
  tsf_mode_t       mode_o;
  tsf_ch2b_t       ch2b_i;
  tsf_chan_t [2:0] chan_i;
  logic [31:0]     rd_q;
  int              err_total = 0;
  int              samples_checked = 0;

  always #2 clk_i = ~clk_i;

  tsf_status_top tsf_status_top_inst (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .ch2b_i(ch2b_i), .chan_i(chan_i),
    .st2b_o(st2b_o), .st3_o(st3_o), .mode_o(mode_o), .irq_o(irq_o));

  task report_and_stop;
    $display("Comparisons %0d, mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Idle cycle first, so a caller may change inputs at the acknowledging edge
  task bus(input logic [7:0] a, input logic w, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_sel_i <= bsel;
    wb_adr_i <= a;
    wb_dat_i <= {16'h0000, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 16);
    rd_q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    if (n >= 16) begin
      err_total++;
      report_and_stop();
    end
  endtask

  task rdc(input logic [7:0] a, input logic [31:0] e);
    bus(a, 1'b0, 16'h0000);
    chk(rd_q, e);
  endtask

  task rwc(input logic [7:0] a, input logic [31:0] e);
    rdc(a, e);
    bus(a, 1'b1, 16'h0000);
    rdc(a, 32'h0);
  endtask

  task step(input logic [15:0] v);
    ch2b_i.cnt <= v;
    for (int i = 0; i < 3; i++) chan_i[i].cnt <= v;
    @(posedge clk_i);
  endtask

  // Compare values that the test counters never reach
  task cmp_def;
    ch2b_i.ocr <= {8{16'h8000}};
    for (int i = 0; i < 3; i++) chan_i[i].gr <= {4{16'h8000}};
    @(posedge clk_i);
  endtask

  task t_rst;
    for (int i = 0; i < 6; i++) rdc(8'(4 * i), 32'h0);
  endtask

  task t_ovf;
    logic [31:0] e;
    step(16'hffff);
    step(16'h0000);
    for (int i = 0; i < 2; i++) begin
      e = (i == 0) ? 32'h0100 : 32'h4210;
      rdc(8'(4 * i), e);
      bus(8'(4 * i), 1'b1, e[15:0]);
      bus(8'(4 * i), 1'b1, 16'h0000);
      rwc(8'(4 * i), e);
    end
  endtask

  task t_cmp;
    for (int i = 0; i < 8; i++) ch2b_i.ocr[i] <= 16'(i + 1);
    chan_i[2].gr[3] <= 16'h0003;
    chan_i[2].gr[2] <= 16'h0004;
    @(posedge clk_i);
    for (int v = 1; v <= 8; v++) step(16'(v));
    rdc(8'h00, 32'h00ff);
    // Zero write through the upper lane only must leave the match flags alone
    bsel = 4'h2;
    bus(8'h00, 1'b1, 16'h0000);
    bsel = 4'h3;
    rwc(8'h00, 32'h00ff);
    rwc(8'h04, 32'h3000);
    cmp_def();
    step(16'h0000);
  endtask

  task t_cap;
    bus(8'h10, 1'b1, 16'h0c00);
    chan_i[2].capture <= 4'hc;
    @(posedge clk_i);
    chan_i[2].capture <= 4'h0;
    rwc(8'h04, 32'h3000);
  endtask

  task t_pwm;
    bus(8'h10, 1'b1, 16'h7000);
    chan_i[2].gr[3] <= 16'h0005;
    chan_i[2].gr[2] <= 16'h0005;
    chan_i[1].gr[3] <= 16'h0005;
    chan_i[1].gr[2] <= 16'h0005;
    chan_i[0].gr[3] <= 16'h0005;
    chan_i[0].gr[0] <= 16'h0005;
    step(16'h0005);
    chk({17'h0, mode_o}, 32'h7000);
    rwc(8'h04, 32'h2108);
    rdc(8'h10, 32'h7000);
    cmp_def();
    step(16'h0000);
  endtask

  task t_race;
    bus(8'h10, 1'b1, 16'h0001);
    chan_i[0].capture <= 4'h1;
    rdc(8'h04, 32'h0001);
    bus(8'h04, 1'b1, 16'h0000);
    chan_i[0].capture <= 4'h0;
    rwc(8'h04, 32'h0001);
    bus(8'h10, 1'b1, 16'h0000);
  endtask

  task t_irq;
    bus(8'h0c, 1'b1, 16'h4000);
    step(16'hffff);
    step(16'h0000);
    repeat (2) @(posedge clk_i);
    chk({31'h0, irq_o}, 32'h1);
    chk({st2b_o, st3_o}, 32'h0100_4210);
    bus(8'h0c, 1'b1, 16'h0000);
    repeat (2) @(posedge clk_i);
    chk({31'h0, irq_o}, 32'h0);
    // Second mask stays set so the mid-run reset has something to clear
    bus(8'h08, 1'b1, 16'h0100);
    repeat (2) @(posedge clk_i);
    chk({31'h0, irq_o}, 32'h1);
    rwc(8'h00, 32'h0100);
    chk({31'h0, irq_o}, 32'h0);
    rwc(8'h04, 32'h4210);
  endtask

  // A wrap while the clock enable is low must go unseen
  task t_ce;
    ce_i <= 1'b0;
    step(16'hffff);
    step(16'h0000);
    ce_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk({st2b_o, st3_o}, 32'h0000_0000);
  endtask

  task t_rst2;
    step(16'hffff);
    step(16'h0000);
    @(posedge clk_i);
    chk({st2b_o, st3_o}, 32'h0100_4210);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    t_rst();
    chk({31'h0, irq_o}, 32'h0);
  endtask

  initial begin
    ch2b_i = '0;
    chan_i = '0;
    ch2b_i.ocr = {8{16'h8000}};
    for (int i = 0; i < 3; i++) chan_i[i].gr = {4{16'h8000}};
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    t_rst();
    t_ovf();
    t_cmp();
    t_cap();
    t_pwm();
    t_race();
    t_irq();
    t_ce();
    t_rst2();
    report_and_stop();
  end
endmodule

bind tsf_status_top tsf_status_checker tsf_status_checker_inst (
  .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_ack_o(wb_ack_o), .ch2b_i(ch2b_i), .chan_i(chan_i),
  .st2b_o(st2b_o), .st3_o(st3_o), .mode_o(mode_o), .irq_o(irq_o));

// >>> test/tsf_status_checker.sv
`timescale 1ns/1ns
module tsf_status_checker
  import tsf_pkg::*;
(
  input  wire logic                     clk_i,    // Clock
  input  wire logic                     rst_i,    // Sync reset
  input  wire logic                     ce_i,     // Clock enable
  input  wire logic                     wb_cyc_i, // Bus cycle
  input  wire logic                     wb_stb_i, // Bus strobe
  input  wire logic                     wb_we_i,  // Bus write
  input  wire logic                     wb_ack_o, // Bus acknowledge
  input  wire tsf_pkg::tsf_ch2b_t       ch2b_i,   // Second counter
  input  wire tsf_pkg::tsf_chan_t [2:0] chan_i,   // Channels 3 to 5
  input  wire logic [15:0]              st2b_o,   // Second-counter flags
  input  wire logic [15:0]              st3_o,    // Group flags
  input  wire tsf_pkg::tsf_mode_t       mode_o,   // Mode settings
  input  wire logic                     irq_o     // Interrupt
);
  default clocking cb @(posedge clk_i); endclocking

  logic hold_q;
  logic hold2_q;

  // Disable reads current values, so the edge of a release or resume would
  // otherwise start attempts on samples taken while reset or freeze held
  always_ff @(posedge clk_i) begin
    hold_q  <= rst_i || !ce_i;
    hold2_q <= hold_q;
  end

  // A frozen clock enable holds every flop, so timing relations pause with it
  default disable iff (rst_i || !ce_i || hold_q || hold2_q);

  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_wrap2;
    $past(ch2b_i.cnt) == 16'hffff && ch2b_i.cnt == 16'h0000;
  endsequence
  sequence s_wrap5;
    $past(chan_i[2].cnt) == 16'hffff && chan_i[2].cnt == 16'h0000;
  endsequence
  sequence s_wrap4;
    $past(chan_i[1].cnt) == 16'hffff && chan_i[1].cnt == 16'h0000;
  endsequence

  bus_answer_a: assert property (s_req |=> wb_ack_o)
    else $error("no acknowledge one cycle after request");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge longer than one cycle");
  rsv_zero_a: assert property (st3_o[15] == 1'b0 && st2b_o[15:9] == 7'h00)
    else $error("reserved status bit set");
  ovf_second_a: assert property (s_wrap2 |=> st2b_o[8])
    else $error("second counter wrap not flagged");
  ovf_ch5_a: assert property (s_wrap5 |=> st3_o[14])
    else $error("channel 5 wrap not flagged");
  ovf_ch4_a: assert property (s_wrap4 |=> st3_o[9])
    else $error("channel 4 wrap not flagged");
  match_first_a: assert property (ch2b_i.cnt != $past(ch2b_i.cnt) &&
    ch2b_i.cnt == ch2b_i.ocr[0] |=> st2b_o[0])
    else $error("first compare match not flagged");
  flag_hold_a: assert property (!$past(wb_ack_o && wb_we_i) |->
    ({st2b_o, st3_o} & $past({st2b_o, st3_o})) == $past({st2b_o, st3_o}))
    else $error("flag fell without a write");
  pwm_quiet_a: assert property (mode_o.pwm[2] |=> !$rose(st3_o[12]))
    else $error("third flag set in pwm mode");
  irq_idle_a: assert property (st2b_o == 16'h0000 && st3_o == 16'h0000 |=> !irq_o)
    else $error("interrupt without a flag");
endmodule
